//--- hw/dbt_top.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
// Operation
// - Clear on A, high on A, low on B
// - Match strobe fires on next count clock
// - Output pin follows select bits on match
// - Select codes: keep, low, high, toggle
// - Counter clears on match A or B
// - Counter clears on external clear rising edge
// - Wrap flag set on FF to 00
// - Channel 0 select 100 forms 16-bit counter
// - 16-bit flags: ch0 full, ch1 low byte
// - 16-bit match clears both; ch1 select ignored
// - 16-bit output pins follow their matches
// - Channel 1 select 100 counts ch0 A
// - Three enabled requests, A above B above wrap
// - Transfer requests from A and B only
// - Conversion start only from ch0 match A
// - Clear beats counter write
// - Counter write beats increment
// - Match value write suppresses match strobe
// - Simultaneous matches: toggle, high, low, none
// - Count falling edges of internal clocks, including select switches other than into cascade
// - Both cascade modes stop both counters
// - Flags clear by read-one-write-zero; A and B flags also by transfer
module dbt_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire dbt_pkg::dbt_bus_t bus,
  output logic [7:0] rdata,
  // Pins
  input wire logic [1:0] ext_clk_pin,
  input wire logic [1:0] ext_clear_pin,
  output logic timer_out_pin_ch0,
  output logic timer_out_pin_ch1,
  // Requests, one bit per channel; irq_top a two-bit code per channel
  output logic [1:0] match_a_irq,
  output logic [1:0] match_b_irq,
  output logic [1:0] wrap_irq,
  output logic [1:0][1:0] irq_top,
  output logic [1:0] xfer_req_a,
  output logic [1:0] xfer_req_b,
  input wire logic [1:0] xfer_ack_a,
  input wire logic [1:0] xfer_ack_b,
  output logic adc_start
);
  // =====================================
  // Reset release
  logic [1:0] rsync;
  logic rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsync <= 2'h0;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_n = rsync[1];

  // =====================================
  // Helpers
  function automatic logic hit(input logic [3:0] a, input logic ch, input logic [2:0] r);
    return a == {ch, r};
  endfunction

  function automatic logic sel_lvl(input logic [2:0] cks, input logic [12:0] pre,
                                   input logic ext);
    case (cks)
      dbt_pkg::CKS_P1: sel_lvl = pre[dbt_pkg::TAP1];
      dbt_pkg::CKS_P2: sel_lvl = pre[dbt_pkg::TAP2];
      dbt_pkg::CKS_P3: sel_lvl = pre[dbt_pkg::TAP3];
      dbt_pkg::CKS_EXT_R, dbt_pkg::CKS_EXT_F, dbt_pkg::CKS_EXT_B: sel_lvl = ext;
      default: sel_lvl = 1'b0;
    endcase
  endfunction

  // Stop and cascade read as a low level, so leaving a high clock counts once in stop, not in cascade
  function automatic logic clk_edge(input logic [2:0] cks, input logic prv, input logic cur);
    case (cks)
      dbt_pkg::CKS_EXT_R: clk_edge = ~prv & cur;
      dbt_pkg::CKS_EXT_B: clk_edge = prv ^ cur;
      default: clk_edge = prv & ~cur;
    endcase
  endfunction

  function automatic logic [1:0] pri(input logic [2:0] p);
    if (p[1]) begin
      pri = dbt_pkg::PRI_A;
    end else if (p[2]) begin
      pri = dbt_pkg::PRI_B;
    end else if (p[0]) begin
      pri = dbt_pkg::PRI_W;
    end else begin
      pri = dbt_pkg::PRI_NONE;
    end
  endfunction

  // =====================================
  // Next state
  dbt_pkg::dbt_state_t q;
  dbt_pkg::dbt_state_t d;
  logic [1:0] ot;
  logic [1:0] t;
  logic [1:0] ha;
  logic [1:0] hb;
  logic [1:0] clr;
  logic [1:0] er;
  logic [1:0] wc;
  logic [1:0] wa;
  logic [1:0] wb;
  logic [1:0] ws;
  logic [1:0] wrap;
  logic [1:0] cur;
  logic [1:0] tick0m;
  logic [1:0] eqa;
  logic [1:0] eqb;
  logic [1:0][1:0] csel;
  logic [1:0][1:0] code;
  logic c16;
  logic cmc;

  always_comb begin
    d = q;
    d.pre = q.pre + 1'b1;
    d.adc = 1'b0;
    c16 = q.ctl[0][2:0] == dbt_pkg::CKS_CASC;
    cmc = q.ctl[1][2:0] == dbt_pkg::CKS_CASC;
    for (int c = 0; c < 2; c++) begin
      d.eck[c] = {q.eck[c][1:0], ext_clk_pin[c]};
      d.ecl[c] = {q.ecl[c][1:0], ext_clear_pin[c]};
      cur[c] = sel_lvl(q.ctl[c][2:0], q.pre, q.eck[c][1]);
      d.lvl[c] = cur[c];
      ot[c] = clk_edge(q.ctl[c][2:0], q.lvl[c], cur[c]);
      er[c] = q.ecl[c][1] & ~q.ecl[c][2];
      csel[c] = q.ctl[c][dbt_pkg::CTL_CLR_HI:dbt_pkg::CTL_CLR_LO];
      wc[c] = bus.wr & hit(bus.addr, c[0], dbt_pkg::REG_CNT);
      wa[c] = bus.wr & hit(bus.addr, c[0], dbt_pkg::REG_MA);
      wb[c] = bus.wr & hit(bus.addr, c[0], dbt_pkg::REG_MB);
      ws[c] = bus.wr & hit(bus.addr, c[0], dbt_pkg::REG_STAT);
      eqa[c] = q.cnt[c] == q.ma[c];
      eqb[c] = q.cnt[c] == q.mb[c];
    end
    // upper channel compares the whole 16 bits
    if (c16) begin
      eqa[0] = {q.cnt[0], q.cnt[1]} == {q.ma[0], q.ma[1]};
      eqb[0] = {q.cnt[0], q.cnt[1]} == {q.mb[0], q.mb[1]};
    end
    if (c16 && cmc) begin
      t = 2'b00;
      tick0m = 2'b00;
    end else if (c16) begin
      // low byte carries into high byte
      t[1] = ot[1];
      t[0] = t[1] & (q.cnt[1] == dbt_pkg::CNT_MAX);
      tick0m = {t[1], t[1]};
    end else begin
      t[0] = ot[0];
      t[1] = ot[1];
      tick0m = {t[1], t[0]};
    end
    // strobe in the last state before the update
    ha[0] = (c16 ? t[1] : t[0]) & eqa[0] & ~wa[0];
    hb[0] = (c16 ? t[1] : t[0]) & eqb[0] & ~wb[0];
    // channel 1 counts ch0 match A
    if (cmc && !c16) begin
      t[1] = ha[0];
    end
    ha[1] = t[1] & eqa[1] & ~wa[1];
    hb[1] = t[1] & eqb[1] & ~wb[1];
    for (int c = 0; c < 2; c++) begin
      clr[c] = (csel[c] == dbt_pkg::CLR_A & ha[c]) | (csel[c] == dbt_pkg::CLR_B & hb[c]) |
               (csel[c] == dbt_pkg::CLR_EXT & er[c]);
    end
    // lower byte clears only with the upper
    if (c16) begin
      clr[1] = clr[0];
    end
    for (int c = 0; c < 2; c++) begin
      wrap[c] = t[c] & (q.cnt[c] == dbt_pkg::CNT_MAX) & ~clr[c] & ~wc[c];
      if (clr[c]) begin
        d.cnt[c] = dbt_pkg::CNT_RST;
      end else if (wc[c]) begin
        d.cnt[c] = bus.wdata;
      end else if (t[c]) begin
        d.cnt[c] = q.cnt[c] + 1'b1;
      end
      if (wa[c]) begin
        d.ma[c] = bus.wdata;
      end
      if (wb[c]) begin
        d.mb[c] = bus.wdata;
      end
      if (bus.wr && hit(bus.addr, c[0], dbt_pkg::REG_CTRL)) begin
        d.ctl[c] = bus.wdata;
      end
      // clear needs an armed read of one; set wins
      if (bus.rd && hit(bus.addr, c[0], dbt_pkg::REG_STAT)) begin
        d.arm[c] = q.flg[c];
      end
      d.flg[c] = q.flg[c];
      if (ws[c]) begin
        d.flg[c] = q.flg[c] & ~(q.arm[c] & ~bus.wdata[dbt_pkg::STS_FLG_B:dbt_pkg::STS_FLG_W]);
        d.arm[c] = 3'h0;
        d.osel[c] = bus.wdata[dbt_pkg::STS_OS_HI:0];
        if (c == 0) begin
          d.ate = bus.wdata[dbt_pkg::STS_ATE];
        end
      end
      d.flg[c][2] = d.flg[c][2] & ~xfer_ack_b[c];
      d.flg[c][1] = d.flg[c][1] & ~xfer_ack_a[c];
      d.flg[c] = d.flg[c] | {hb[c], ha[c], wrap[c]};
      code[c] = ha[c] ? q.osel[c][1:0] : 2'h0;
      if (hb[c] && q.osel[c][3:2] > code[c]) begin
        code[c] = q.osel[c][3:2];
      end
      case (code[c])
        dbt_pkg::OS_TOG: d.tout[c] = ~q.tout[c];
        dbt_pkg::OS_HIGH: d.tout[c] = 1'b1;
        dbt_pkg::OS_LOW: d.tout[c] = 1'b0;
        default: d.tout[c] = q.tout[c];
      endcase
    end
    d.adc = ha[0] & q.ate;
    d.rdat = 8'h00;
    if (bus.rd) begin
      for (int c = 0; c < 2; c++) begin
        if (hit(bus.addr, c[0], dbt_pkg::REG_CTRL)) begin
          d.rdat = q.ctl[c];
        end else if (hit(bus.addr, c[0], dbt_pkg::REG_STAT)) begin
          d.rdat = {q.flg[c], (c == 0) ? q.ate : 1'b1, q.osel[c]};
        end else if (hit(bus.addr, c[0], dbt_pkg::REG_CNT)) begin
          d.rdat = q.cnt[c];
        end else if (hit(bus.addr, c[0], dbt_pkg::REG_MA)) begin
          d.rdat = q.ma[c];
        end else if (hit(bus.addr, c[0], dbt_pkg::REG_MB)) begin
          d.rdat = q.mb[c];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ma <= {2{dbt_pkg::MATCH_RST}};
      q.mb <= {2{dbt_pkg::MATCH_RST}};
    end else begin
      q <= d;
    end
  end

  // =====================================
  // Outputs
  assign rdata = q.rdat;
  assign timer_out_pin_ch0 = q.tout[0];
  assign timer_out_pin_ch1 = q.tout[1];
  assign adc_start = q.adc;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_req
      assign match_a_irq[g] = q.flg[g][1] & q.ctl[g][dbt_pkg::CTL_IE_A];
      assign match_b_irq[g] = q.flg[g][2] & q.ctl[g][dbt_pkg::CTL_IE_B];
      assign wrap_irq[g] = q.flg[g][0] & q.ctl[g][dbt_pkg::CTL_IE_W];
      assign irq_top[g] = pri({match_b_irq[g], match_a_irq[g], wrap_irq[g]});
      assign xfer_req_a[g] = match_a_irq[g];
      assign xfer_req_b[g] = match_b_irq[g];
    end
  endgenerate

  // =====================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_clear_on_a: assert property (ha[0] && csel[0] == 2'h1 |=> q.cnt[0] == 8'h00)
    else $error("counter not cleared on match A");
  a_pulse_high: assert property (ha[1] && !hb[1] && q.osel[1] == 4'h6 && !c16 |=> q.tout[1])
    else $error("pulse output not high on match A");
  a_flag_follows: assert property (ha[1] |=> q.flg[1][1])
    else $error("match A flag not set after strobe");
  a_out_toggle: assert property (ha[0] && !hb[0] && q.osel[0][1:0] == 2'h3
    |=> q.tout[0] != $past(q.tout[0]))
    else $error("toggle select did not toggle");
  a_wrap_sets: assert property (wrap[1] |=> q.flg[1][0] && q.cnt[1] == 8'h00)
    else $error("wrap flag not set on wrap");
  a_casc_carry: assert property (c16 && !cmc && wrap[1] && !clr[0] && !wc[0]
    |=> q.cnt[0] == $past(q.cnt[0]) + 8'h01)
    else $error("upper byte did not take carry");
  a_casc_clear: assert property (c16 && clr[0] |=> q.cnt[0] == 8'h00 && q.cnt[1] == 8'h00)
    else $error("16-bit clear missed a byte");
  a_cmc_count: assert property (cmc && !c16 && ha[0] && !clr[1] && !wc[1]
    |=> q.cnt[1] == $past(q.cnt[1]) + 8'h01)
    else $error("match count mode missed a count");
  a_adc_cause: assert property (adc_start |-> $past(ha[0]) && $past(q.ate))
    else $error("conversion start without cause");
  a_write_wins: assert property (wc[0] && !clr[0] |=> q.cnt[0] == $past(bus.wdata))
    else $error("counter write lost");
  a_clear_wins: assert property (wc[1] && clr[1] |=> q.cnt[1] == 8'h00)
    else $error("clear lost to write");
  a_match_inhibit: assert property (wa[0] |-> !ha[0])
    else $error("strobe during match value write");
  a_both_stop: assert property (c16 && cmc |-> t == 2'b00)
    else $error("count clock in forbidden mode");
endmodule

//--- hw/dbt_pkg.sv
package dbt_pkg;
  // =====================================
  // Register map: addr[3] picks the channel, addr[2:0] the register
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_CNT = 3'h2;
  localparam logic [2:0] REG_MA = 3'h3;
  localparam logic [2:0] REG_MB = 3'h4;
  // =====================================
  // timer_control_reg fields
  localparam int CTL_IE_B = 7;
  localparam int CTL_IE_A = 6;
  localparam int CTL_IE_W = 5;
  localparam int CTL_CLR_HI = 4;
  localparam int CTL_CLR_LO = 3;
  localparam int CTL_CKS_HI = 2;
  // timer_ctrl_status_reg fields
  localparam int STS_FLG_B = 7;
  localparam int STS_FLG_A = 6;
  localparam int STS_FLG_W = 5;
  localparam int STS_ATE = 4;
  localparam int STS_OS_HI = 3;
  // =====================================
  // Codes
  localparam logic [2:0] CKS_P1 = 3'h1;
  localparam logic [2:0] CKS_P2 = 3'h2;
  localparam logic [2:0] CKS_P3 = 3'h3;
  localparam logic [2:0] CKS_CASC = 3'h4;
  localparam logic [2:0] CKS_EXT_R = 3'h5;
  localparam logic [2:0] CKS_EXT_F = 3'h6;
  localparam logic [2:0] CKS_EXT_B = 3'h7;
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_EXT = 2'h3;
  localparam logic [1:0] OS_LOW = 2'h1;
  localparam logic [1:0] OS_HIGH = 2'h2;
  localparam logic [1:0] OS_TOG = 2'h3;
  // Priority codes of the pending request, one per channel
  localparam logic [1:0] PRI_NONE = 2'h0;
  localparam logic [1:0] PRI_A = 2'h1;
  localparam logic [1:0] PRI_B = 2'h2;
  localparam logic [1:0] PRI_W = 2'h3;
  // =====================================
  // Prescaler taps for internal clocks /8, /64, /8192
  localparam int PRE_W = 13;
  localparam int TAP1 = 2;
  localparam int TAP2 = 5;
  localparam int TAP3 = 12;
  // Reset values and counter maximum
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'hFF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // Least external pulse widths, in half states; one state is one clk
  localparam int EXT_SINGLE_HALF = 3;
  localparam int EXT_BOTH_HALF = 5;
  localparam int EXT_SINGLE_CYC = (EXT_SINGLE_HALF + 1) / 2;
  localparam int EXT_BOTH_CYC = (EXT_BOTH_HALF + 1) / 2;
  // =====================================
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dbt_bus_t;

  typedef struct packed {
    logic [1:0][7:0] ctl;
    logic [1:0][7:0] cnt;
    logic [1:0][7:0] ma;
    logic [1:0][7:0] mb;
    logic [1:0][2:0] flg;
    logic [1:0][2:0] arm;
    logic [1:0][3:0] osel;
    logic ate;
    logic [1:0] tout;
    logic [1:0] lvl;
    logic [1:0][2:0] eck;
    logic [1:0][2:0] ecl;
    logic [PRE_W-1:0] pre;
    logic adc;
    logic [7:0] rdat;
  } dbt_state_t;
endpackage

//--- verif/dbt_xfer_model.sv
`timescale 1ns/1ns
// =====================================
// Transfer controller stand-in: answers each pending request with a
// one-cycle ack, and only while the bench lets it, so software-side
// flag clearing can be tested without it racing the bench.
module dbt_xfer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control from the bench
  input wire logic ack_en,
  // Requests and acks
  input wire logic [1:0] xfer_req_a,
  input wire logic [1:0] xfer_req_b,
  output logic [1:0] xfer_ack_a,
  output logic [1:0] xfer_ack_b
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_ack_a <= 2'h0;
      xfer_ack_b <= 2'h0;
    end else begin
      xfer_ack_a <= ack_en ? (xfer_req_a & ~xfer_ack_a) : 2'h0;
      xfer_ack_b <= ack_en ? (xfer_req_b & ~xfer_ack_b) : 2'h0;
    end
  end
endmodule

//--- verif/dbt_top_tb_top.sv
`timescale 1ns/1ns
module dbt_top_tb_top;
  logic clk;
  logic rst_b;
  dbt_pkg::dbt_bus_t bus;
  logic [7:0] rdata;
  logic [1:0] ext_clk_pin;
  logic [1:0] ext_clear_pin;
  logic timer_out_pin_ch0;
  logic timer_out_pin_ch1;
  logic [1:0] match_a_irq;
  logic [1:0] match_b_irq;
  logic [1:0] wrap_irq;
  logic [1:0][1:0] irq_top;
  logic [1:0] xfer_req_a;
  logic [1:0] xfer_req_b;
  logic [1:0] xfer_ack_a;
  logic [1:0] xfer_ack_b;
  logic adc_start;
  logic ack_en;
  int fails;
  int check_count;
  int adc_cnt;

  dbt_top dut (
    .clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .ext_clk_pin(ext_clk_pin), .ext_clear_pin(ext_clear_pin),
    .timer_out_pin_ch0(timer_out_pin_ch0), .timer_out_pin_ch1(timer_out_pin_ch1),
    .match_a_irq(match_a_irq), .match_b_irq(match_b_irq), .wrap_irq(wrap_irq),
    .irq_top(irq_top), .xfer_req_a(xfer_req_a), .xfer_req_b(xfer_req_b),
    .xfer_ack_a(xfer_ack_a), .xfer_ack_b(xfer_ack_b), .adc_start(adc_start)
  );

  dbt_xfer_model u_xfer (
    .clk(clk), .rst_b(rst_b), .ack_en(ack_en),
    .xfer_req_a(xfer_req_a), .xfer_req_b(xfer_req_b),
    .xfer_ack_a(xfer_ack_a), .xfer_ack_b(xfer_ack_b)
  );

  // =====================================
  // Clock, monitor, hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (adc_start === 1'b1) adc_cnt++;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  // =====================================
  // Helpers
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    // Let the write settle before a caller looks at outputs
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Pulses held two states, above the least width, then settle time
  // pin pulse width
  task pulse(input bit clr, input int ch);
    @(posedge clk);
    if (clr) ext_clear_pin[ch] <= 1'b1;
    else ext_clk_pin[ch] <= 1'b1;
    repeat (2) @(posedge clk);
    if (clr) ext_clear_pin[ch] <= 1'b0;
    else ext_clk_pin[ch] <= 1'b0;
    repeat (7) @(posedge clk);
    #1;
  endtask

  task results;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // =====================================
  // Main sequence; map: addr[3] channel, 0 ctrl 1 status 2 count 3 A 4 B
  initial begin
    rst_b = 1'b0;
    bus = '0;
    ext_clk_pin = 2'h0;
    ext_clear_pin = 2'h0;
    ack_en = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(4'h3, 8'hFF);
    rdchk(4'h9, 8'h10);
    rdchk(4'h5, 8'h00);
    // Pulse output: clear on A, high on A, low on B, external rising clock
    wr(4'h3, 8'h03);
    wr(4'h4, 8'h01);
    wr(4'h1, 8'h16);
    wr(4'h0, 8'h0D);
    repeat (4) pulse(1'b0, 0);
    rdchk(4'h2, 8'h00);
    chk({7'h00, timer_out_pin_ch0}, 8'h01);
    chk(adc_cnt[7:0], 8'h01);
    // Zero write without a prior read leaves flags set
    wr(4'h1, 8'h16);
    rdchk(4'h1, 8'hD6);
    wr(4'h0, 8'hED);
    chk({6'h00, irq_top[0]}, {6'h00, dbt_pkg::PRI_A});
    chk({6'h00, match_b_irq}, 8'h01);
    wr(4'h1, 8'h16);
    rdchk(4'h1, 8'h16);
    chk({6'h00, irq_top[0]}, {6'h00, dbt_pkg::PRI_NONE});
    wr(4'h0, 8'h0D);
    repeat (2) pulse(1'b0, 0);
    chk({7'h00, timer_out_pin_ch0}, 8'h00);
    rdchk(4'h2, 8'h02);
    // External clear
    wr(4'h0, 8'h1D);
    pulse(1'b1, 0);
    rdchk(4'h2, 8'h00);
    // Channel 1 wrap with only the wrap request enabled
    wr(4'hA, 8'hFF);
    wr(4'h8, 8'h25);
    pulse(1'b0, 1);
    rdchk(4'hA, 8'h00);
    chk({6'h00, wrap_irq}, 8'h02);
    chk({6'h00, irq_top[1]}, {6'h00, dbt_pkg::PRI_W});
    chk({4'h0, xfer_req_a, xfer_req_b}, 8'h00);
    rdchk(4'h9, 8'hF0);
    chk(adc_cnt[7:0], 8'h01);
    // Transfer acks clear compare flags, never the wrap flag
    ack_en <= 1'b1;
    wr(4'h8, 8'hE5);
    repeat (4) @(posedge clk);
    rdchk(4'h9, 8'h30);
    chk({6'h00, irq_top[1]}, {6'h00, dbt_pkg::PRI_W});
    ack_en <= 1'b0;
    // 16-bit cascade: carry from channel 1 into channel 0
    wr(4'h0, 8'h04);
    wr(4'h2, 8'h00);
    wr(4'h8, 8'h05);
    wr(4'hA, 8'hFF);
    pulse(1'b0, 1);
    rdchk(4'hA, 8'h00);
    rdchk(4'h2, 8'h01);
    chk({7'h00, timer_out_pin_ch1}, 8'h00);
    results();
  end
endmodule
